// ---- bench/prs_ref_model.sv ----
// Model of the two reference clock sources at the block's far side.
// Assumes the bench says when each source runs; a stopped one stays low.
`timescale 1ns/100ps

module prs_ref_model (
    input  wire logic run_a_i,  // Source A enabled
    input  wire logic run_b_i,  // Source B enabled
    output logic      ref_a_o,  // Reference pin A
    output logic      ref_b_o   // Reference pin B
);
    //------------------------------------------------------------
    // Clock sources
    //------------------------------------------------------------
    // Within 20 percent of each other, so automatic sensing applies
    localparam real HALF_A = 41.0;
    localparam real HALF_B = 43.0;

    // Source A, stuck low while stopped
    initial begin
        ref_a_o = 1'b0;
        forever begin
            #(HALF_A);
            ref_a_o = run_a_i ? ~ref_a_o : 1'b0;
        end
    end

    // Source B, stuck low while stopped
    initial begin
        ref_b_o = 1'b0;
        forever begin
            #(HALF_B);
            ref_b_o = run_b_i ? ~ref_b_o : 1'b0;
        end
    end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the reference switchover block.
// Assumes the reference source model and the block's package.
`timescale 1ns/100ps

module tb_top
    import prs_pkg::*;
;
    //------------------------------------------------------------
    // Signals
    //------------------------------------------------------------
    logic         clock_i;   // System clock
    logic         rst_n_i;   // Reset, active low
    logic         req;       // Switch request
    logic         full;      // Full variant strap
    logic         auto_en;   // Automatic mode strap
    logic         casc;      // Divider chain strap
    logic         run_a;     // Source A running
    logic         run_b;     // Source B running
    logic         ref_a;     // Pin A
    logic         ref_b;     // Pin B
    logic         sel;       // Mux select
    logic         t1;        // First divider tick
    logic         t2;        // Second divider tick
    logic         gate_seen; // Path gated at some point
    prs_div_cfg_t div_cfg;   // Divider settings
    prs_status_t  status;    // Status bundle
    int           n_fail;    // Mismatches
    int           num_checks; // Comparisons
    int           cyc;       // Cycle count for the timeout
    int           g;         // Measured tick gap

    //------------------------------------------------------------
    // Instances
    //------------------------------------------------------------
    prs_pll_ref_switch i_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i),
        .ref_input_a_i(ref_a), .ref_input_b_i(ref_b),
        .switch_req_i(req), .full_variant_i(full),
        .auto_enable_i(auto_en), .cascade_strap_i(casc),
        .div_cfg_i(div_cfg), .status_o(status), .ref_select_o(sel),
        .div_first_tick_o(t1), .div_second_tick_o(t2)
    );
    prs_ref_model i_src (
        .run_a_i(run_a), .run_b_i(run_b),
        .ref_a_o(ref_a), .ref_b_o(ref_b)
    );

    //------------------------------------------------------------
    // Clock, timeout and gate monitor
    //------------------------------------------------------------
    always #5 clock_i = ~clock_i;

    // Hang guard, well above the expected run length
    always @(posedge clock_i) begin
        if (status.ref_gate_on === 1'b0)
            gate_seen = 1'b1;
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            print_verdict();
        end
    end

    //------------------------------------------------------------
    // Tasks
    //------------------------------------------------------------
    // One edge, then the drive delay
    task automatic step();
        @(posedge clock_i);
        #1;
    endtask

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Watched flag: 0 select, 1 fault A, 2 fault B
    function automatic logic cur(input int w);
        case (w)
            0: cur = sel;
            1: cur = status.ref_a_fault;
            default: cur = status.ref_b_fault;
        endcase
    endfunction

    // Bounded wait for a flag level
    task automatic wait_sig(input int w, input logic v);
        int k;
        for (k = 0; k < 400 && cur(w) !== v; k++)
            step();
        chk(16'(cur(w)), 16'(v));
    endtask

    // Cycles between two ticks of one divider
    task automatic tick_gap(input int w, output int gap);
        int k;
        for (k = 0; k < 3000 && (w == 1 ? t1 : t2) !== 1'b1; k++)
            step();
        gap = 0;
        do begin
            step();
            gap++;
        end while ((w == 1 ? t1 : t2) !== 1'b1 && gap < 3000);
    endtask

    // Reset with the given straps, held steady over release
    task automatic do_reset(input logic f, input logic a, input logic c);
        rst_n_i = 1'b0;
        full = f;
        auto_en = a;
        casc = c;
        repeat (6) step();
        rst_n_i = 1'b1;
        repeat (20) step();
    endtask

    // Closing report
    task automatic print_verdict();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    //------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        rst_n_i = 1'b0;
        req = 1'b0;
        run_a = 1'b1;
        run_b = 1'b1;
        full = 1'b1;
        auto_en = 1'b1;
        casc = 1'b1;
        n_fail = 0;
        num_checks = 0;
        cyc = 0;
        gate_seen = 1'b0;
        div_cfg = '{post_divider_first: 10'h004, post_divider_second: 10'h002};
        do_reset(1'b1, 1'b1, 1'b1);
        // Quiet state with both clocks running
        chk(16'(status), 16'h0005);
        chk(16'(sel), 16'h0000);
        repeat (200) step();
        chk(16'({status.ref_a_fault, status.ref_b_fault}), 16'h0000);
        // Chained dividers
        tick_gap(1, g);
        chk(16'(g), 16'h0004);
        casc = 1'b0;
        tick_gap(2, g);
        chk(16'(g), 16'h0008);
        div_cfg.post_divider_first = 10'h200;
        tick_gap(2, g);
        tick_gap(2, g);
        chk(16'(g), 16'h0400);
        // Failover on loss of A
        run_a = 1'b0;
        wait_sig(1, 1'b1);
        chk(16'(status.loss_n), 16'h0000);
        wait_sig(0, 1'b1);
        chk(16'({status.active_clock, status.ref_b_fault}), 16'h0002);
        // A back: faults clear, no return
        run_a = 1'b1;
        wait_sig(1, 1'b0);
        repeat (200) step();
        chk(16'(sel), 16'h0001);
        run_b = 1'b0;
        wait_sig(2, 1'b1);
        repeat (100) step();
        chk(16'(sel), 16'h0001);
        run_b = 1'b1;
        wait_sig(2, 1'b0);
        // Override swap back to A, both running
        gate_seen = 1'b0;
        req = 1'b1;
        wait_sig(0, 1'b0);
        chk(16'(gate_seen), 16'h0001);
        chk(16'(status), 16'h0005);
        req = 1'b0;
        repeat (100) step();
        chk(16'({sel, status.loss_n}), 16'h0000);
        // Override toward a dead target waits
        run_b = 1'b0;
        wait_sig(2, 1'b1);
        req = 1'b1;
        repeat (150) step();
        chk(16'(sel), 16'h0000);
        run_b = 1'b1;
        wait_sig(0, 1'b1);
        chk(16'({status.active_clock, status.loss_n}), 16'h0003);
        req = 1'b0;
        // Fast variant: level select, no chain, no failover
        div_cfg.post_divider_first = 10'h004;
        do_reset(1'b0, 1'b0, 1'b1);
        tick_gap(2, g);
        chk(16'(g), 16'h0002);
        req = 1'b1;
        wait_sig(0, 1'b1);
        req = 1'b0;
        wait_sig(0, 1'b0);
        run_a = 1'b0;
        repeat (200) step();
        chk(16'(sel), 16'h0000);
        print_verdict();
    end
endmodule

// ---- hw/prs_pkg.sv ----
// Constants, types and state codes for the reference switchover block.
// Assumes one 100 MHz system clock that oversamples both reference pins.
package prs_pkg;

    //--------------------------------------------------------------------
    // Edge supervision
    //--------------------------------------------------------------------
    localparam int       CNT_W      = 2;       // Edge counter width
    localparam logic [1:0] EDGE_NONE = 2'h0;   // No edge seen
    localparam logic [1:0] EDGE_ONE  = 2'h1;   // One edge seen
    localparam logic [1:0] EDGE_TWO  = 2'h2;   // Two edges seen
    localparam logic [1:0] EDGE_MISS = 2'h3;   // Other input missed one

    //--------------------------------------------------------------------
    // Post-scale dividers
    //--------------------------------------------------------------------
    localparam int          DIV_W   = 10;      // Holds settings 1..512
    localparam logic [9:0]  DIV_MAX = 10'h200; // Largest single setting
    localparam logic [9:0]  DIV_ONE = 10'h001; // Smallest setting
    localparam logic [9:0]  DIV_NIL = 10'h000; // Counter start

    // Switch sequence state of the reference selection
    typedef enum logic [1:0] {
        PRS_RUN  = 2'b00,   // Supervising, path enabled
        PRS_GATE = 2'b01,   // Waiting for falling edge of current input
        PRS_WAIT = 2'b11    // Path gated, waiting for target falling edge
    } prs_state_t;

    // Runtime divider settings
    typedef struct packed {
        logic [DIV_W-1:0] post_divider_first;   // First counter setting
        logic [DIV_W-1:0] post_divider_second;  // Second counter setting
    } prs_div_cfg_t;

    // Status seen by user logic
    typedef struct packed {
        logic ref_a_fault;    // Input A missed edges
        logic ref_b_fault;    // Input B missed edges
        logic loss_n;         // Low marks a switch condition
        logic active_clock;   // 0 input A, 1 input B
        logic ref_gate_on;    // Reference path to loop enabled
    } prs_status_t;

endpackage

// ---- hw/prs_pll_ref_switch.sv ----
// Reference clock selection, supervision and post-scale dividers.
// Assumes both reference pins run below a quarter of clock_i, and that
// the strap inputs are steady across the release of rst_n_i.
`timescale 1ns/100ps

module prs_pll_ref_switch
    import prs_pkg::*;
(
    input  wire logic         clock_i,          // 100 MHz system clock
    input  wire logic         rst_n_i,          // Async reset, active low
    input  wire logic         ref_input_a_i,    // Reference pin A
    input  wire logic         ref_input_b_i,    // Reference pin B
    input  wire logic         switch_req_i,     // Switch request pin
    input  wire logic         full_variant_i,   // Strap: full-featured
    input  wire logic         auto_enable_i,    // Strap: automatic mode
    input  wire logic         cascade_strap_i,  // Strap: chain dividers
    input  wire prs_div_cfg_t div_cfg_i,        // Runtime divider settings
    output prs_status_t       status_o,         // Fault, loss, active
    output logic              ref_select_o,     // Internal mux select
    output logic              div_first_tick_o, // First divider output
    output logic              div_second_tick_o // Second divider output
);

    //--------------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------------
    logic [2:0] sync_a;     // Stage 0,1 sync, stage 2 edge history
    logic [2:0] sync_b;     // Same for input B
    logic [1:0] sync_req;   // Request synchroniser
    logic       req_d;      // Request history for edge detect

    // Two stages before any logic, then one history stage
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_a   <= 3'h0;
            sync_b   <= 3'h0;
            sync_req <= 2'h0;
            req_d    <= 1'b0;
        end else begin
            sync_a   <= {sync_a[1:0], ref_input_a_i};
            sync_b   <= {sync_b[1:0], ref_input_b_i};
            sync_req <= {sync_req[0], switch_req_i};
            req_d    <= sync_req[1];
        end
    end

    logic rise_a;   // Rising edge of input A
    logic rise_b;   // Rising edge of input B
    logic fall_a;   // Falling edge of input A
    logic fall_b;   // Falling edge of input B
    logic req_s;    // Synchronised request level
    logic req_rise; // Request rising edge

    assign rise_a   = sync_a[1] & ~sync_a[2];
    assign rise_b   = sync_b[1] & ~sync_b[2];
    assign fall_a   = ~sync_a[1] & sync_a[2];
    assign fall_b   = ~sync_b[1] & sync_b[2];
    assign req_s    = sync_req[1];
    assign req_rise = req_s & ~req_d;

    //--------------------------------------------------------------------
    // Configuration capture
    //--------------------------------------------------------------------
    logic cfg_done;     // Straps captured
    logic mode_auto;    // Automatic switching with override
    logic cascade_on;   // Dividers chained
    logic next_cfg_done;
    logic next_mode_auto;
    logic next_cascade_on;

    // Straps are taken once after reset; later changes have no effect
    always_comb begin
        next_cfg_done   = 1'b1;
        next_mode_auto  = mode_auto;
        next_cascade_on = cascade_on;
        if (!cfg_done) begin
            next_mode_auto  = full_variant_i & auto_enable_i;
            next_cascade_on = full_variant_i & cascade_strap_i;
        end
    end

    // Configuration registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_done   <= 1'b0;
            mode_auto  <= 1'b0;
            cascade_on <= 1'b0;
        end else begin
            cfg_done   <= next_cfg_done;
            mode_auto  <= next_mode_auto;
            cascade_on <= next_cascade_on;
        end
    end

    //--------------------------------------------------------------------
    // Switchover state machine and edge supervision
    //--------------------------------------------------------------------
    prs_state_t       state;        // Switch sequence state
    logic             sel;          // Mux select, 1 means input B
    logic             gate_on;      // Reference path enabled
    logic             ovr_active;   // Last switch was an override
    logic [CNT_W-1:0] edge_count_a; // Edges seen on input A
    logic [CNT_W-1:0] edge_count_b; // Edges seen on input B
    logic             fault_a;      // Input A missed an edge
    logic             fault_b;      // Input B missed an edge

    prs_state_t       next_state;
    logic             next_sel;
    logic             next_gate_on;
    logic             next_ovr_active;
    logic [CNT_W-1:0] next_count_a;
    logic [CNT_W-1:0] next_count_b;
    logic             next_fault_a;
    logic             next_fault_b;
    logic             cur_fault;    // Selected input faulty
    logic             fall_cur;     // Falling edge of selected input
    logic             fall_tgt;     // Falling edge of target input

    assign cur_fault = sel ? fault_b : fault_a;
    assign fall_cur  = sel ? fall_b : fall_a;
    assign fall_tgt  = sel ? fall_a : fall_b;

    // Counts edges, flags misses, sequences glitch-free swaps
    always_comb begin
        next_state      = state;
        next_sel        = sel;
        next_gate_on    = gate_on;
        next_ovr_active = ovr_active;
        next_fault_a    = fault_a;
        next_fault_b    = fault_b;
        next_count_a    = edge_count_a;
        next_count_b    = edge_count_b;
        unique case (state)
            PRS_RUN: begin
                // Saturating per-input edge counts
                if (rise_a && edge_count_a != EDGE_MISS) begin
                    next_count_a = edge_count_a + EDGE_ONE;
                end
                if (rise_b && edge_count_b != EDGE_MISS) begin
                    next_count_b = edge_count_b + EDGE_ONE;
                end
                if (next_count_a != EDGE_NONE && next_count_a != EDGE_MISS
                    && next_count_b != EDGE_NONE
                    && next_count_b != EDGE_MISS) begin
                    // Both inputs alive: clear together
                    next_count_a = EDGE_NONE;
                    next_count_b = EDGE_NONE;
                    next_fault_a = 1'b0;
                    next_fault_b = 1'b0;
                end else if (next_count_a == EDGE_MISS) begin
                    next_fault_b = 1'b1;
                    next_count_a = EDGE_NONE;
                    next_count_b = EDGE_NONE;
                end else if (next_count_b == EDGE_MISS) begin
                    next_fault_a = 1'b1;
                    next_count_a = EDGE_NONE;
                    next_count_b = EDGE_NONE;
                end
                // Start a swap: failover, override edge, or level select
                if (mode_auto && !sel && fault_a) begin
                    next_state      = PRS_GATE;
                    next_ovr_active = 1'b0;
                end else if (mode_auto && req_rise) begin
                    next_state      = PRS_GATE;
                    next_ovr_active = 1'b1;
                end else if (!mode_auto && (req_s != sel)) begin
                    next_state      = PRS_GATE;
                    next_ovr_active = 1'b0;
                end
            end
            PRS_GATE: begin
                // Gate on falling edge, or at once if input is dead
                if (fall_cur || cur_fault) begin
                    next_gate_on = 1'b0;
                    next_state   = PRS_WAIT;
                end
            end
            PRS_WAIT: begin
                // Hold until target toggles, then switch
                if (fall_tgt) begin
                    next_sel     = ~sel;
                    next_gate_on = 1'b1;
                    next_state   = PRS_RUN;
                    next_count_a = EDGE_NONE;
                    next_count_b = EDGE_NONE;
                end
            end
            default: begin
                next_state   = PRS_RUN;
                next_gate_on = 1'b1;
            end
        endcase
    end

    // Supervision and sequence registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state        <= PRS_RUN;
            sel          <= 1'b0;
            gate_on      <= 1'b1;
            ovr_active   <= 1'b0;
            edge_count_a <= EDGE_NONE;
            edge_count_b <= EDGE_NONE;
            fault_a      <= 1'b0;
            fault_b      <= 1'b0;
        end else begin
            state        <= next_state;
            sel          <= next_sel;
            gate_on      <= next_gate_on;
            ovr_active   <= next_ovr_active;
            edge_count_a <= next_count_a;
            edge_count_b <= next_count_b;
            fault_a      <= next_fault_a;
            fault_b      <= next_fault_b;
        end
    end

    // Status: loss mirrors request during override, else fault of selected input
    assign status_o.ref_a_fault  = fault_a;
    assign status_o.ref_b_fault  = fault_b;
    assign status_o.loss_n       = ovr_active ? req_s : ~cur_fault;
    assign status_o.active_clock = sel;
    assign status_o.ref_gate_on  = gate_on;
    assign ref_select_o          = sel;

    //--------------------------------------------------------------------
    // Post-scale dividers
    //--------------------------------------------------------------------
    logic [DIV_W-1:0] div_cnt_first;   // First counter position
    logic [DIV_W-1:0] div_cnt_second;  // Second counter position
    logic             tick_first;      // First counter terminal
    logic             tick_second;     // Second counter terminal
    logic             adv_second;      // Second counter advances
    logic [DIV_W-1:0] set_first;       // Clamped first setting
    logic [DIV_W-1:0] set_second;      // Clamped second setting
    logic [DIV_W-1:0] next_cnt_first;
    logic [DIV_W-1:0] next_cnt_second;

    // Settings outside 1..512 are clamped
    always_comb begin
        set_first  = div_cfg_i.post_divider_first;
        set_second = div_cfg_i.post_divider_second;
        if (set_first == DIV_NIL) set_first = DIV_ONE;
        if (set_first > DIV_MAX) set_first = DIV_MAX;
        if (set_second == DIV_NIL) set_second = DIV_ONE;
        if (set_second > DIV_MAX) set_second = DIV_MAX;
        tick_first  = (div_cnt_first >= set_first - DIV_ONE);
        adv_second  = cascade_on ? tick_first : 1'b1;
        tick_second = adv_second
                      && (div_cnt_second >= set_second - DIV_ONE);
        next_cnt_first  = tick_first ? DIV_NIL : div_cnt_first + DIV_ONE;
        next_cnt_second = div_cnt_second;
        if (adv_second) begin
            next_cnt_second = tick_second ? DIV_NIL
                                          : div_cnt_second + DIV_ONE;
        end
    end

    // Divider registers and registered outputs
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt_first     <= DIV_NIL;
            div_cnt_second    <= DIV_NIL;
            div_first_tick_o  <= 1'b0;
            div_second_tick_o <= 1'b0;
        end else begin
            div_cnt_first     <= next_cnt_first;
            div_cnt_second    <= next_cnt_second;
            div_first_tick_o  <= tick_first;
            div_second_tick_o <= tick_second;
        end
    end

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_fail_direction: assert property (
        sel && !next_sel |-> ovr_active || !mode_auto)
        else $error("automatic switch returned to input A");

    a_fail_start: assert property (
        state == PRS_RUN && mode_auto && !sel && fault_a
        |=> state == PRS_GATE)
        else $error("failover not started on input A fault");

    a_pair_clear: assert property (
        state == PRS_RUN && edge_count_a == EDGE_ONE
        && edge_count_b == EDGE_NONE && rise_b && !rise_a
        |=> edge_count_a == EDGE_NONE && edge_count_b == EDGE_NONE)
        else $error("edge counters did not clear on pair");

    a_miss_flag: assert property (
        state == PRS_RUN && edge_count_b == EDGE_TWO
        && edge_count_a == EDGE_NONE && rise_b && !rise_a
        |=> fault_a)
        else $error("missed edge on input A not flagged");

    a_gate_hold: assert property (
        state == PRS_WAIT |-> !gate_on)
        else $error("reference path open while switching");

    a_switch_edge: assert property (
        $changed(sel) |-> $past(fall_tgt) && $past(state) == PRS_WAIT
        && gate_on && status_o.active_clock == sel)
        else $error("select changed off target falling edge");

    a_ovr_loss: assert property (
        ovr_active |-> status_o.loss_n == req_s)
        else $error("loss does not mirror request in override");

    a_ovr_nofault: assert property (
        state != PRS_RUN |=> $stable(fault_a) && $stable(fault_b))
        else $error("fault flag changed during a swap");

    a_fall_noswap: assert property (
        mode_auto && state == PRS_RUN && !req_rise && !(fault_a && !sel)
        |=> state == PRS_RUN)
        else $error("swap started without request rising edge");

    a_cascade_lock: assert property (
        cfg_done |=> $stable(cascade_on) [*4])
        else $error("divider chaining changed after configuration");

    a_level_sel: assert property (
        !mode_auto && cfg_done && state == PRS_RUN && req_s != sel
        |=> state == PRS_GATE)
        else $error("manual level select did not start a swap");

    a_chain_adv: assert property (
        cascade_on && !tick_first |=> $stable(div_cnt_second))
        else $error("chained divider advanced without first tick");

endmodule
